// *** ioenc_top.sv ***
// Purpose: Encode slave read/write bursts into request size fields
// Assumes: Requests come from logic on CLOCK; one request per cycle
// Notes:   WIDE selects the 64-bit datapath, else 32-bit
`include "ioenc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ioenc_top #(
  parameter bit WIDE = 1'b1,
  parameter int BC_W = `IOENC_BC_W
) (
  input wire logic CLOCK, // 200 MHz system clock
  input wire logic RST_N, // Asynchronous reset, active low
  input wire logic RD_REQ, // Read request taken this cycle
  input wire logic [BC_W-1:0] RD_BURSTCOUNT, // Read beats
  input wire logic RD_ADDR2, // Read word address bit 2
  input wire logic RD_BEAT, // One read data beat returned
  input wire logic WR_REQ, // Write request taken this cycle
  input wire logic [BC_W-1:0] WR_BURSTCOUNT, // Write beats
  input wire logic [7:0] WR_BYTEENABLE, // Lanes; narrow uses [3:0]
  input wire logic WR_ADDR2, // Write word address bit 2
  input wire logic [`IOENC_FLAG_W-1:0] FLAG_CLEAR, // Clear flags, pulse
  input wire logic [`IOENC_FLAG_W-1:0] IRQ_ENABLE, // Flag irq enables
  output ioenc_pkg::ioenc_req_t REQ, // Encoded request
  output logic REQ_VALID, // REQ valid, one cycle
  output logic RD_ERROR, // Read burst errored, level
  output logic [`IOENC_FLAG_W-1:0] FLAGS, // Sticky status flags
  output logic MNT_IRQ // Maintenance interrupt
);

  // ----------------------------------------
  // Size functions
  // ----------------------------------------
  // Doubleword count to read size code
  function automatic logic [4:0] rd_code(input logic [BC_W-1:0] n);
    logic [BC_W-1:0] k;
    logic [BC_W-1:0] s;
    k = (n - 1'b1) >> 2;
    s = (k - 2'd2) >> 1;
    if (n <= 1) rd_code = {1'b0, `IOENC_SZ_DW};
    else if (n == 2) rd_code = {1'b1, `IOENC_SZ_DW};
    else if (n <= 4) rd_code = {1'b0, `IOENC_SZ_4DW};
    else if (n <= 8) rd_code = {1'b1, `IOENC_SZ_4DW};
    else rd_code = {k[0], `IOENC_SZ_8DW + s[3:0]};
  endfunction

  // Doubleword count to write size code (legal counts only)
  function automatic logic [4:0] wr_code(input logic [BC_W-1:0] n);
    if (n <= 8 || !WIDE) wr_code = rd_code(n);
    else if (n <= 16) wr_code = {1'b1, `IOENC_SZ_8DW};
    else wr_code = {1'b1, `IOENC_SZ_32DW};
  endfunction

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  ioenc_pkg::ioenc_code_t lane_code;
  logic [BC_W-1:0] rd_dw;
  logic [BC_W-1:0] wr_dw;
  logic [4:0] rd_enc;
  logic [4:0] wr_enc;
  logic wr_multi;
  logic rd_range;
  logic wr_range;
  logic wr_burst_bad;
  logic wr_lanes_bad;
  logic wr_illegal;
  logic lanes_full;
  logic [`IOENC_FLAG_W-1:0] flag_set;

  ioenc_lanes #(.WIDE(WIDE)) u_lanes (
    .mask(WR_BYTEENABLE),
    .addr2(WR_ADDR2),
    .code(lane_code)
  );

  always_comb begin
    // Narrow path counts in doublewords: two words each
    rd_dw = WIDE ? RD_BURSTCOUNT : BC_W'((RD_BURSTCOUNT + 1'b1) >> 1);
    wr_dw = WIDE ? WR_BURSTCOUNT : BC_W'(WR_BURSTCOUNT >> 1);
    rd_enc = rd_code(rd_dw);
    wr_enc = wr_code(wr_dw);
    wr_multi = WR_BURSTCOUNT > 1;
    lanes_full = WIDE ? (WR_BYTEENABLE == `IOENC_LANES_FULL)
                      : (WR_BYTEENABLE[3:0] == 4'hf);
    rd_range = RD_REQ && RD_BURSTCOUNT > 1 && RD_ADDR2;
    wr_range = WR_REQ && wr_multi && WR_ADDR2;
    wr_burst_bad = WR_REQ && !WIDE && wr_multi
                   && WR_BURSTCOUNT[0];
    wr_lanes_bad = WR_REQ && wr_multi && !lanes_full;
    // Unlisted wide combinations: zero, over-long or unknown mask
    wr_illegal = WR_REQ && WIDE
                 && ((WR_BURSTCOUNT == '0)
                     || (WR_BURSTCOUNT > `IOENC_MAX_BURST_64)
                     || (!wr_multi && !lane_code.ok));
    if (!WIDE && WR_REQ && ((WR_BURSTCOUNT == '0)
        || (WR_BURSTCOUNT > `IOENC_MAX_BURST_32)
        || (!wr_multi && !lane_code.ok)))
      wr_illegal = 1'b1;
    flag_set = '0;
    flag_set[`IOENC_FLG_WR_RANGE] = wr_range;
    flag_set[`IOENC_FLG_RD_RANGE] = rd_range;
    flag_set[`IOENC_FLG_WR_BURST] = wr_burst_bad;
    flag_set[`IOENC_FLG_WR_LANES] = wr_lanes_bad;
    flag_set[`IOENC_FLG_WR_ILLEGAL] = wr_illegal;
  end

  // ----------------------------------------
  // Encoded request output
  // ----------------------------------------
  // Write wins when both arrive; the read is encoded the next time
  // it is presented, so the master must not drop it.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      REQ <= '0;
      REQ_VALID <= 1'b0;
    end else begin
      REQ_VALID <= WR_REQ | RD_REQ;
      if (WR_REQ) begin
        REQ.is_write <= 1'b1;
        REQ.error <= wr_range | wr_burst_bad | wr_lanes_bad | wr_illegal;
        if (wr_multi) begin
          REQ.wdptr <= wr_enc[4];
          REQ.size <= wr_enc[3:0];
        end else begin
          REQ.wdptr <= lane_code.wdptr;
          REQ.size <= lane_code.size;
        end
      end else if (RD_REQ) begin
        REQ.is_write <= 1'b0;
        REQ.error <= rd_range;
        REQ.wdptr <= rd_enc[4];
        REQ.size <= rd_enc[3:0];
      end
    end
  end

  // ----------------------------------------
  // Read error for the whole burst
  // ----------------------------------------
  logic [BC_W-1:0] rd_left_reg;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_left_reg <= '0;
    end else if (RD_REQ && !WR_REQ && rd_range) begin
      rd_left_reg <= RD_BURSTCOUNT;
    end else if (RD_BEAT && rd_left_reg != '0) begin
      rd_left_reg <= rd_left_reg - 1'b1;
    end
  end

  // Only the requested beats are counted, not the rounded size
  assign RD_ERROR = rd_left_reg != '0;

  // ----------------------------------------
  // Sticky flags and interrupt
  // ----------------------------------------
  logic [`IOENC_FLAG_W-1:0] rd_flag_mask;

  always_comb begin
    // A read losing to a simultaneous write is not flagged yet
    rd_flag_mask = '1;
    rd_flag_mask[`IOENC_FLG_RD_RANGE] = ~WR_REQ;
  end

  // Set beats clear in the same cycle
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      FLAGS <= '0;
    end else begin
      FLAGS <= (FLAGS & ~FLAG_CLEAR)
               | (flag_set & rd_flag_mask);
    end
  end

  assign MNT_IRQ = |(FLAGS & IRQ_ENABLE);

endmodule
`default_nettype wire

// *** ioenc_cfg.svh ***
// Purpose: Constants for the slave request size encoder
// Assumes: Included by bare name wherever needed
// Notes:   Definitions only
`ifndef IOENC_CFG_SVH
`define IOENC_CFG_SVH

// ----------------------------------------
// Burst limits
// ----------------------------------------
`define IOENC_BC_W 7
`define IOENC_MAX_BURST_64 7'h20
`define IOENC_MAX_BURST_32 7'h40

// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define IOENC_FLAG_W 5
`define IOENC_FLG_WR_RANGE 0
`define IOENC_FLG_RD_RANGE 1
`define IOENC_FLG_WR_BURST 2
`define IOENC_FLG_WR_LANES 3
`define IOENC_FLG_WR_ILLEGAL 4

// ----------------------------------------
// Size codes
// ----------------------------------------
`define IOENC_SZ_DW 4'hb
`define IOENC_SZ_4DW 4'hc
`define IOENC_SZ_8DW 4'hd
`define IOENC_SZ_16DW 4'he
`define IOENC_SZ_32DW 4'hf
`define IOENC_SZ_WORD32 4'h8
`define IOENC_LANES_FULL 8'hff

`endif

// *** ioenc_pkg.sv ***
// Purpose: Types for the slave request size encoder
// Assumes: Nothing
// Notes:   Types only; numbers live in ioenc_cfg.svh
`default_nettype none
package ioenc_pkg;

  typedef struct packed {
    logic       is_write;
    logic       wdptr;
    logic [3:0] size;
    logic       error;
  } ioenc_req_t;

  typedef struct packed {
    logic       ok;
    logic       wdptr;
    logic [3:0] size;
  } ioenc_code_t;

endpackage
`default_nettype wire

// *** ioenc_lanes.sv ***
// Purpose: Single-beat write lane mask to wdptr/wrsize
// Assumes: Combinational, mask already sampled
// Notes:   ok low means the mask has no encoding
`include "ioenc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ioenc_lanes #(
  parameter bit WIDE = 1'b1
) (
  input wire logic [7:0] mask, // Byte lanes
  input wire logic addr2, // Word address bit 2 (narrow path)
  output ioenc_pkg::ioenc_code_t code // Encoding
);

  logic [3:0] m4;

  always_comb begin
    m4 = mask[3:0];
    code = '0;
    code.ok = 1'b1;
    if (WIDE) begin
      case (mask)
        8'h80: code = '{1'b1, 1'b0, 4'h0};
        8'h40: code = '{1'b1, 1'b0, 4'h1};
        8'h20: code = '{1'b1, 1'b0, 4'h2};
        8'h10: code = '{1'b1, 1'b0, 4'h3};
        8'h08: code = '{1'b1, 1'b1, 4'h0};
        8'h04: code = '{1'b1, 1'b1, 4'h1};
        8'h02: code = '{1'b1, 1'b1, 4'h2};
        8'h01: code = '{1'b1, 1'b1, 4'h3};
        8'hc0: code = '{1'b1, 1'b0, 4'h5};
        8'he0: code = '{1'b1, 1'b0, 4'h6};
        8'h30: code = '{1'b1, 1'b0, 4'h7};
        8'hf8: code = '{1'b1, 1'b0, 4'h8};
        8'h0c: code = '{1'b1, 1'b1, 4'h8};
        8'h07: code = '{1'b1, 1'b1, 4'h9};
        8'h03: code = '{1'b1, 1'b1, 4'h9};
        8'h1f: code = '{1'b1, 1'b1, 4'ha};
        8'hf0: code = '{1'b1, 1'b0, 4'h8};
        8'h0f: code = '{1'b1, 1'b1, 4'h8};
        8'hfc: code = '{1'b1, 1'b0, 4'h9};
        8'h3f: code = '{1'b1, 1'b1, 4'h9};
        8'hfe: code = '{1'b1, 1'b0, 4'ha};
        8'h7f: code = '{1'b1, 1'b1, 4'ha};
        8'hff: code = '{1'b1, 1'b0, 4'hb};
        default: code = '0;
      endcase
    end else begin
      // Narrow path: upper word when address bit 2 is set
      code.wdptr = ~addr2;
      case (m4)
        4'h8: code.size = 4'h0;
        4'h4: code.size = 4'h1;
        4'h2: code.size = 4'h2;
        4'h1: code.size = 4'h3;
        4'hc: code.size = 4'h4;
        4'he: code.size = 4'h5;
        4'h7: code.size = 4'h5;
        4'h3: code.size = 4'h6;
        4'hf: code.size = `IOENC_SZ_WORD32;
        default: code.ok = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** ioenc_master.sv ***
// Purpose: Bus master model issuing slave read/write requests
// Assumes: Drives 1 ns after CLOCK rises
// Notes:   Idle fields carry random junk
`timescale 1ns/1ps
`default_nettype none
module ioenc_master (
  input wire logic clock, // Clock
  output logic rd_req, // Read request
  output logic [6:0] rd_bc, // Read beats
  output logic rd_a2, // Read address bit 2
  output logic wr_req, // Write request
  output logic [6:0] wr_bc, // Write beats
  output logic [7:0] wr_be, // Lanes
  output logic wr_a2 // Write address bit 2
);
  task automatic idle;
    @(posedge clock);
    #1;
    rd_req = 1'b0;
    wr_req = 1'b0;
    {rd_bc, rd_a2, wr_bc, wr_be, wr_a2} = 24'($urandom);
  endtask
  // Stays high when called back to back
  task automatic send(input logic w, input logic [6:0] bc,
                      input logic [7:0] be, input logic a2);
    @(posedge clock);
    #1;
    wr_req = w;
    rd_req = !w;
    rd_bc = bc;
    wr_bc = bc;
    rd_a2 = a2;
    wr_a2 = a2;
    wr_be = be;
  endtask
  initial begin
    rd_req = 1'b0;
    wr_req = 1'b0;
    {rd_bc, rd_a2, wr_bc, wr_be, wr_a2} = 24'h0;
  end
endmodule
`default_nettype wire

// *** ioenc_top_chk.sv ***
// Purpose: Port checks for the request size encoder
// Assumes: Bound onto ioenc_top
// Notes:   One clock domain
`timescale 1ns/1ps
`default_nettype none
module ioenc_top_chk #(
  parameter bit WIDE = 1'b1,
  parameter int BC_W = 7
) (
  input wire logic CLOCK, // Clock
  input wire logic RST_N, // Reset
  input wire logic RD_REQ, // Read request
  input wire logic [BC_W-1:0] RD_BURSTCOUNT, // Read beats
  input wire logic RD_ADDR2, // Read bit 2
  input wire logic RD_BEAT, // Read beat
  input wire logic WR_REQ, // Write request
  input wire logic [BC_W-1:0] WR_BURSTCOUNT, // Write beats
  input wire logic [7:0] WR_BYTEENABLE, // Lanes
  input wire logic WR_ADDR2, // Write bit 2
  input wire logic [4:0] FLAG_CLEAR, // Clears
  input wire logic [4:0] IRQ_ENABLE, // Enables
  input wire ioenc_pkg::ioenc_req_t REQ, // Request
  input wire logic REQ_VALID, // Valid
  input wire logic RD_ERROR, // Read error
  input wire logic [4:0] FLAGS, // Flags
  input wire logic MNT_IRQ // Interrupt
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  wire logic rd_go = RD_REQ && !WR_REQ;
  wire logic wr_multi = WR_REQ && WR_BURSTCOUNT > 1;
  a_req_answer: assert property ((WR_REQ || RD_REQ) |=> REQ_VALID)
    else $error("no answer");
  a_wr_range: assert property (wr_multi && WR_ADDR2 |=> FLAGS[0] && REQ.error)
    else $error("range flag");
  a_wr_lanes: assert property (WIDE && wr_multi && WR_BYTEENABLE != 8'hff |=> FLAGS[3])
    else $error("lane flag");
  a_narrow_odd: assert property (!WIDE && wr_multi && WR_BURSTCOUNT[0] |=> FLAGS[2])
    else $error("odd flag");
  a_rd_range: assert property (rd_go && RD_BURSTCOUNT > 1 && RD_ADDR2 |=> FLAGS[1] && RD_ERROR)
    else $error("read range");
  a_rd_err_hold: assert property (RD_ERROR && !RD_BEAT && !RD_REQ |=> RD_ERROR)
    else $error("read error drop");
  a_lane_irq: assert property ($rose(FLAGS[3]) && IRQ_ENABLE[3] |-> MNT_IRQ)
    else $error("no irq");
  a_full_beat: assert property (WIDE && WR_REQ && WR_BURSTCOUNT == 1 && WR_BYTEENABLE == 8'hff |=> !REQ.wdptr && REQ.size == 4'hb)
    else $error("full beat");
  a_rd_size: assert property (WIDE && rd_go && RD_BURSTCOUNT inside {[3:4]} |=> !REQ.wdptr && REQ.size == 4'hc)
    else $error("read size");
endmodule
bind ioenc_top ioenc_top_chk #(.WIDE(WIDE), .BC_W(BC_W)) u_chk (
  .CLOCK(CLOCK), .RST_N(RST_N), .RD_REQ(RD_REQ),
  .RD_BURSTCOUNT(RD_BURSTCOUNT), .RD_ADDR2(RD_ADDR2), .RD_BEAT(RD_BEAT),
  .WR_REQ(WR_REQ), .WR_BURSTCOUNT(WR_BURSTCOUNT), .WR_ADDR2(WR_ADDR2),
  .WR_BYTEENABLE(WR_BYTEENABLE), .FLAG_CLEAR(FLAG_CLEAR),
  .IRQ_ENABLE(IRQ_ENABLE), .REQ(REQ), .REQ_VALID(REQ_VALID),
  .RD_ERROR(RD_ERROR), .FLAGS(FLAGS), .MNT_IRQ(MNT_IRQ));
`default_nettype wire

// *** io_slave_request_size_encoder_test.sv ***
// Purpose: Self-checking bench for the request size encoder
// Assumes: 64-bit datapath in full; 32-bit copy checked for flags
// Notes:   Expected codes queued before each request
`timescale 1ns/1ps
`default_nettype none
module io_slave_request_size_encoder_test;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic rd_beat = 1'b0;
  logic [4:0] flag_clear = 5'h00;
  logic [4:0] irq_en = 5'h1f;
  logic rd_req, wr_req, rd_a2, wr_a2, req_valid, rd_error, irq;
  logic [6:0] rd_bc, wr_bc;
  logic [7:0] wr_be;
  logic [4:0] flags;
  logic [4:0] narrow_flags;
  logic [13:0] e;
  ioenc_pkg::ioenc_req_t req;
  logic [13:0] q[$];
  int n_errors = 0;
  int n_compared = 0;
  // Mask, then wdptr nibble, then size nibble
  logic [15:0] lanes [23] = '{16'h8000, 16'h4001, 16'h2002, 16'h1003,
    16'h0810, 16'h0411, 16'h0212, 16'h0113, 16'hc005, 16'he006, 16'h3007,
    16'hf808, 16'h0c18, 16'h0719, 16'h0319, 16'h1f1a, 16'hf008, 16'h0f18,
    16'hfc09, 16'h3f19, 16'hfe0a, 16'h7f1a, 16'hff0b};
  always #2.5 clock = ~clock;
  ioenc_top #(.WIDE(1'b1)) u_ioenc_top (.CLOCK(clock), .RST_N(rst_n),
    .RD_REQ(rd_req), .RD_BURSTCOUNT(rd_bc), .RD_ADDR2(rd_a2),
    .RD_BEAT(rd_beat), .WR_REQ(wr_req), .WR_BURSTCOUNT(wr_bc),
    .WR_BYTEENABLE(wr_be), .WR_ADDR2(wr_a2), .FLAG_CLEAR(flag_clear),
    .IRQ_ENABLE(irq_en), .REQ(req), .REQ_VALID(req_valid),
    .RD_ERROR(rd_error), .FLAGS(flags), .MNT_IRQ(irq));
  ioenc_master u_ioenc_master (.clock(clock), .rd_req(rd_req),
    .rd_bc(rd_bc), .rd_a2(rd_a2), .wr_req(wr_req), .wr_bc(wr_bc),
    .wr_be(wr_be), .wr_a2(wr_a2));
  // Narrow copy sees the same traffic; only its flags are compared
  ioenc_top #(.WIDE(1'b0)) u_ioenc_top_narrow (.CLOCK(clock),
    .RST_N(rst_n), .RD_REQ(rd_req), .RD_BURSTCOUNT(rd_bc),
    .RD_ADDR2(rd_a2), .RD_BEAT(rd_beat), .WR_REQ(wr_req),
    .WR_BURSTCOUNT(wr_bc), .WR_BYTEENABLE(wr_be), .WR_ADDR2(wr_a2),
    .FLAG_CLEAR(flag_clear), .IRQ_ENABLE(irq_en), .REQ(), .REQ_VALID(),
    .RD_ERROR(), .FLAGS(narrow_flags), .MNT_IRQ());
  task automatic summarize;
    if (n_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic w, input int bc, input logic [7:0] be,
                      input logic a2, input logic [6:0] exp,
                      input logic [6:0] mask);
    q.push_back({mask, exp});
    u_ioenc_master.send(w, 7'(bc), be, a2);
  endtask
  function automatic logic [4:0] rd_code(input int n);
    int k = (n - 1) / 4;
    if (n <= 2)
      return {n == 2, 4'hb};
    return {k[0], 4'hc + 4'(k / 2)};
  endfunction
  function automatic logic [4:0] wr_code(input int n);
    if (n <= 8)
      return rd_code(n);
    return n <= 16 ? 5'h1d : 5'h1f;
  endfunction
  // Sampled mid-cycle, clear of the edge that launches the outputs
  always @(negedge clock) begin
    if (req_valid === 1'b1) begin
      if (q.size() == 0)
        check(8'h00, 8'hff);
      else begin
        e = q.pop_front();
        check({1'b0, req & e[13:7]}, {1'b0, e[6:0]});
      end
    end
  end
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    void'($urandom(64));
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    for (int n = 1; n <= 32; n++)
      send(0, n, 8'hff, n == 1, {1'b0, rd_code(n), 1'b0}, 7'h7f);
    for (int i = 0; i < 23; i++)
      send(1, 1, lanes[i][15:8], 1'($urandom),
           {1'b1, lanes[i][4:0], 1'b0}, 7'h7f);
    for (int n = 2; n <= 32; n++)
      send(1, n, 8'hff, 0, {1'b1, wr_code(n), 1'b0}, 7'h7f);
    u_ioenc_master.idle();
    check({3'h0, flags}, 8'h00);
    check({6'h0, narrow_flags[2:1]}, 8'h02);
    send(1, 2, 8'hff, 1, 7'h41, 7'h41);
    send(1, 4, 8'h7f, 0, 7'h41, 7'h41);
    send(1, 1, 8'h81, 0, 7'h41, 7'h41);
    send(1, 33, 8'hff, 0, 7'h41, 7'h41);
    send(0, 3, 8'hff, 1, 7'h01, 7'h41);
    u_ioenc_master.idle();
    check({3'h0, flags}, 8'h1b);
    check({7'h0, irq}, 8'h01);
    irq_en = 5'h00;
    // One quiet cycle so the error level is seen without a beat
    @(posedge clock);
    #1 check({7'h0, irq}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      check({7'h0, rd_error}, 8'h01);
      rd_beat = 1'b1;
      @(posedge clock);
      #1;
    end
    rd_beat = 1'b0;
    check({7'h0, rd_error}, 8'h00);
    flag_clear = 5'h1f;
    @(posedge clock);
    #1 flag_clear = 5'h00;
    check({3'h0, flags}, 8'h00);
    for (int i = 0; i < 20 && q.size() != 0; i++)
      @(posedge clock);
    check(8'(q.size()), 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
